// ---- common/rx_sens_pkg.sv ----
// What this block does
// - Ratio flag set means the channel's receiver runs a one-to-one transformer.
// - Internal receive termination only usable with one-to-one transformer and flag set.
// - Even channel uses bit 7 and bits 6..4; odd uses bit 3, bits 2..0.
// - Code 000 gives 12/0/15 dB; code 001 gives 18/0/21 dB.
// - Code 100 gives 30/14/37 dB monitor; code 101 gives 22.5/20/45.5 dB.
// - Level code counts 2.5 dB bands below 0 dB; 0111 is the lowest band.
// - Level byte holds even channel in bits 7..4, odd channel in bits 3..0.
// - Config byte for channels 7-8 at 0Bh, channels 15-16 at 2Bh.
// - Level bytes at 0Ch, 0Dh, 0Eh and 2Ch, 2Dh for their pairs.
package rx_sens_pkg;
  localparam int NUM_CH = 16;
  localparam logic [7:0] OFS_CFG_7_8 = 8'h0B;
  localparam logic [7:0] OFS_LVL_1_2 = 8'h0C;
  localparam logic [7:0] OFS_LVL_3_4 = 8'h0D;
  localparam logic [7:0] OFS_LVL_5_6 = 8'h0E;
  localparam logic [7:0] OFS_CFG_15_16 = 8'h2B;
  localparam logic [7:0] OFS_LVL_9_10 = 8'h2C;
  localparam logic [7:0] OFS_LVL_11_12 = 8'h2D;
  localparam logic [7:0] CFG_RESET = 8'h00;
  localparam logic [7:0] LVL_RESET = 8'h00;
  localparam int EVEN_RATIO_BIT = 7;
  localparam int EVEN_SEL_LSB = 4;
  localparam int ODD_RATIO_BIT = 3;
  localparam int ODD_SEL_LSB = 0;
  localparam int EVEN_LVL_LSB = 4;
  localparam int ODD_LVL_LSB = 0;
  localparam logic [3:0] LVL_MAX_CODE = 4'h7;
  localparam logic [2:0] SEL_NORM_12 = 3'h0;
  localparam logic [2:0] SEL_NORM_18 = 3'h1;
  localparam logic [2:0] SEL_MON_14 = 3'h4;
  localparam logic [2:0] SEL_MON_20 = 3'h5;
  // Gains and losses in tenths of a dB
  localparam logic [9:0] MAXLOSS_000 = 10'd120;
  localparam logic [9:0] MAXLOSS_001 = 10'd180;
  localparam logic [9:0] MAXLOSS_100 = 10'd300;
  localparam logic [9:0] MAXLOSS_101 = 10'd225;
  localparam logic [9:0] GAIN_MON_14 = 10'd140;
  localparam logic [9:0] GAIN_MON_20 = 10'd200;
  localparam logic [9:0] DECL_000 = 10'd150;
  localparam logic [9:0] DECL_001 = 10'd210;
  localparam logic [9:0] DECL_100 = 10'd370;
  localparam logic [9:0] DECL_101 = 10'd455;
  localparam logic [9:0] LVL_BAND = 10'd25;
endpackage

// ---- design/rx_cfg_mem.sv ----
`timescale 1ns/1ps
`default_nettype none
// Two config bytes with registered read port
module rx_cfg_mem
  import rx_sens_pkg::*;
(
  input wire logic clk,
  input wire logic srst,
  input wire logic we,
  input wire logic waddr,
  input wire logic [7:0] wdata,
  input wire logic raddr,
  output logic [7:0] rdata,
  output logic [15:0] all_cfg
);
  logic [7:0] mem_r [2];

  always_ff @(posedge clk) begin
    if (srst) begin
      mem_r[0] <= CFG_RESET;
      mem_r[1] <= CFG_RESET;
    end else if (we) begin
      mem_r[waddr] <= wdata;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      rdata <= CFG_RESET;
    end else begin
      rdata <= mem_r[raddr];
    end
  end

  assign all_cfg = {mem_r[1], mem_r[0]};
endmodule
`default_nettype wire

// ---- design/rx_sensitivity_level_regs.sv ----
// Decided for this implementation: the Avalon-MM slave port.
`timescale 1ns/1ps
`default_nettype none
module rx_sensitivity_level_regs
  import rx_sens_pkg::*;
(
  input wire logic clk,
  input wire logic srst,
  input wire logic [7:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  output logic [31:0] readdata,
  output logic waitrequest,
  // Per-channel measured level from the analog front end, channel n at [4n+3:4n]
  input wire logic [63:0] meas_level,
  output logic [3:0] rx_ratio_one_to_one,
  output logic [11:0] rx_sens_monitor_sel,
  output logic [3:0] int_term_allowed,
  output logic [3:0] monitor_mode_en,
  output logic [3:0] sel_reserved,
  output logic [39:0] max_loss_tenth_db,
  output logic [39:0] mon_gain_tenth_db,
  output logic [39:0] loss_decl_tenth_db
);
  ////////////////////////////////////////////////////////////////////////////
  // Bus handshake: one wait cycle per access so the memory read settles
  typedef enum logic [1:0] {
    BUS_IDLE = 2'b00,
    BUS_WAIT = 2'b01,
    BUS_DONE = 2'b11
  } bus_state_e;

  bus_state_e bus_r;
  bus_state_e bus_nxt;
  logic mem_we;
  logic mem_raddr;
  logic [7:0] mem_rdata;
  logic [15:0] cfg_all;
  logic [7:0] lvl_r [5];
  logic is_cfg;
  logic cfg_idx;
  logic [7:0] rd_byte;

  function automatic logic [3:0] clamp_level(input logic [3:0] raw);
    // Anything below -20 dB saturates at the lowest band
    clamp_level = (raw > LVL_MAX_CODE) ? LVL_MAX_CODE : raw;
  endfunction

  // A write waits a cycle as well, so reads and writes share one fixed latency
  always_comb begin
    bus_nxt = bus_r;
    case (bus_r)
      BUS_IDLE: begin
        if (read || write) begin
          bus_nxt = BUS_WAIT;
        end
      end
      BUS_WAIT: bus_nxt = BUS_DONE;
      BUS_DONE: bus_nxt = BUS_IDLE;
      default: bus_nxt = BUS_IDLE;
    endcase
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      bus_r <= BUS_IDLE;
    end else begin
      bus_r <= bus_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Address decode
  // Only the two config offsets reach the memory; level offsets read from flops, others read 00h
  always_comb begin
    is_cfg = 1'b0;
    cfg_idx = 1'b0;
    if (address == OFS_CFG_7_8) begin
      is_cfg = 1'b1;
      cfg_idx = 1'b0;
    end else if (address == OFS_CFG_15_16) begin
      is_cfg = 1'b1;
      cfg_idx = 1'b1;
    end
  end

  // Write lands in the wait cycle; level bytes ignore writes
  assign mem_we = write && is_cfg && (bus_r == BUS_WAIT);
  assign mem_raddr = cfg_idx;

  // The memory read port tracks the address every cycle; the wait cycle covers it
  rx_cfg_mem u_cfg (
    .clk(clk),
    .srst(srst),
    .we(mem_we),
    .waddr(cfg_idx),
    .wdata(writedata[7:0]),
    .raddr(mem_raddr),
    .rdata(mem_rdata),
    .all_cfg(cfg_all)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Level bytes follow the front end every cycle: pairs 1-2,3-4,5-6,9-10,11-12
  // Zero-based low channel of level byte idx; the upper bank skips channels 7 and 8
  function automatic int pair_base(input int idx);
    pair_base = (idx < 3) ? 2 * idx : 2 * idx + 2;
  endfunction

  // Even channel in the high nibble, odd channel in the low nibble
  function automatic logic [7:0] level_pair(input logic [63:0] lvl, input int base);
    level_pair = {clamp_level(lvl[base*4+4 +: 4]), clamp_level(lvl[base*4 +: 4])};
  endfunction

  // Front end codes are taken as synchronous to this clock, so no handshake here
  always_ff @(posedge clk) begin
    if (srst) begin
      for (int i = 0; i < 5; i++) begin
        lvl_r[i] <= LVL_RESET;
      end
    end else begin
      for (int i = 0; i < 5; i++) begin
        lvl_r[i] <= level_pair(meas_level, pair_base(i));
      end
    end
  end

  always_comb begin
    rd_byte = 8'h00;
    if (is_cfg) begin
      rd_byte = mem_rdata;
    end else if (address == OFS_LVL_1_2) begin
      rd_byte = lvl_r[0];
    end else if (address == OFS_LVL_3_4) begin
      rd_byte = lvl_r[1];
    end else if (address == OFS_LVL_5_6) begin
      rd_byte = lvl_r[2];
    end else if (address == OFS_LVL_9_10) begin
      rd_byte = lvl_r[3];
    end else if (address == OFS_LVL_11_12) begin
      rd_byte = lvl_r[4];
    end
  end

  // Waitrequest is high except in the done cycle; registered so the bus sees no glitch
  always_ff @(posedge clk) begin
    if (srst) begin
      waitrequest <= 1'b1;
    end else begin
      waitrequest <= !(bus_nxt == BUS_DONE);
    end
  end

  // Read data captured in the wait cycle and held until the next access
  always_ff @(posedge clk) begin
    if (srst) begin
      readdata <= 32'h0000_0000;
    end else if (bus_r == BUS_WAIT) begin
      readdata <= {24'h00_0000, rd_byte};
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Per-channel decode; index 0..3 = ch7, ch8, ch15, ch16
  logic [3:0] ratio_c;
  logic [11:0] sel_c;

  // Ratio flag and select field of one channel inside a config byte
  function automatic logic ratio_of(input logic [7:0] cfg, input logic odd_ch);
    ratio_of = odd_ch ? cfg[ODD_RATIO_BIT] : cfg[EVEN_RATIO_BIT];
  endfunction

  function automatic logic [2:0] sel_of(input logic [7:0] cfg, input logic odd_ch);
    sel_of = odd_ch ? cfg[ODD_SEL_LSB +: 3] : cfg[EVEN_SEL_LSB +: 3];
  endfunction

  always_comb begin
    for (int b = 0; b < 2; b++) begin
      ratio_c[2*b] = ratio_of(cfg_all[8*b +: 8], 1'b1);
      sel_c[6*b +: 3] = sel_of(cfg_all[8*b +: 8], 1'b1);
      ratio_c[2*b+1] = ratio_of(cfg_all[8*b +: 8], 1'b0);
      sel_c[6*b+3 +: 3] = sel_of(cfg_all[8*b +: 8], 1'b0);
    end
  end

  // Ratio flags steer the receive front end straight from the stored byte
  always_ff @(posedge clk) begin
    if (srst) begin
      rx_ratio_one_to_one <= 4'h0;
    end else begin
      rx_ratio_one_to_one <= ratio_c;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      rx_sens_monitor_sel <= 12'h000;
    end else begin
      rx_sens_monitor_sel <= sel_c;
    end
  end

  // Internal termination gated by the ratio flag; board fit is software's job
  always_ff @(posedge clk) begin
    if (srst) begin
      int_term_allowed <= 4'h0;
    end else begin
      int_term_allowed <= ratio_c;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Select-code decode; reserved codes fall back to the normal 12 dB setting so
  // a stray write never leaves a channel without a loss threshold
  function automatic logic is_monitor(input logic [2:0] code);
    is_monitor = (code == SEL_MON_14) || (code == SEL_MON_20);
  endfunction

  function automatic logic is_reserved(input logic [2:0] code);
    case (code)
      SEL_NORM_12, SEL_NORM_18, SEL_MON_14, SEL_MON_20: is_reserved = 1'b0;
      default: is_reserved = 1'b1;
    endcase
  endfunction

  function automatic logic [9:0] max_loss_of(input logic [2:0] code);
    case (code)
      SEL_NORM_18: max_loss_of = MAXLOSS_001;
      SEL_MON_14: max_loss_of = MAXLOSS_100;
      SEL_MON_20: max_loss_of = MAXLOSS_101;
      default: max_loss_of = MAXLOSS_000;
    endcase
  endfunction

  function automatic logic [9:0] mon_gain_of(input logic [2:0] code);
    case (code)
      SEL_MON_14: mon_gain_of = GAIN_MON_14;
      SEL_MON_20: mon_gain_of = GAIN_MON_20;
      default: mon_gain_of = 10'h000;
    endcase
  endfunction

  function automatic logic [9:0] loss_decl_of(input logic [2:0] code);
    case (code)
      SEL_NORM_18: loss_decl_of = DECL_001;
      SEL_MON_14: loss_decl_of = DECL_100;
      SEL_MON_20: loss_decl_of = DECL_101;
      default: loss_decl_of = DECL_000;
    endcase
  endfunction

  // One block per output; all follow the stored select with the same one-edge lag
  always_ff @(posedge clk) begin
    if (srst) begin
      monitor_mode_en <= 4'h0;
    end else begin
      for (int c = 0; c < 4; c++) begin
        monitor_mode_en[c] <= is_monitor(sel_c[3*c +: 3]);
      end
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      sel_reserved <= 4'h0;
    end else begin
      for (int c = 0; c < 4; c++) begin
        sel_reserved[c] <= is_reserved(sel_c[3*c +: 3]);
      end
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      max_loss_tenth_db <= '0;
    end else begin
      for (int c = 0; c < 4; c++) begin
        max_loss_tenth_db[10*c +: 10] <= max_loss_of(sel_c[3*c +: 3]);
      end
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      mon_gain_tenth_db <= '0;
    end else begin
      for (int c = 0; c < 4; c++) begin
        mon_gain_tenth_db[10*c +: 10] <= mon_gain_of(sel_c[3*c +: 3]);
      end
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      loss_decl_tenth_db <= '0;
    end else begin
      for (int c = 0; c < 4; c++) begin
        loss_decl_tenth_db[10*c +: 10] <= loss_decl_of(sel_c[3*c +: 3]);
      end
    end
  end
endmodule
`default_nettype wire

// ---- tb/rx_sens_monitor.sv ----
`timescale 1ns/1ps
`default_nettype none
module rx_sens_monitor
  import rx_sens_pkg::*;
(
  input wire logic clk,
  input wire logic srst,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] readdata,
  input wire logic waitrequest,
  input wire logic [3:0] rx_ratio_one_to_one,
  input wire logic [11:0] rx_sens_monitor_sel,
  input wire logic [3:0] int_term_allowed,
  input wire logic [3:0] monitor_mode_en,
  input wire logic [3:0] sel_reserved,
  input wire logic [39:0] max_loss_tenth_db,
  input wire logic [39:0] mon_gain_tenth_db,
  input wire logic [39:0] loss_decl_tenth_db
);
  default clocking @(posedge clk); endclocking
  default disable iff (srst);
  logic rst_r;
  always_ff @(posedge clk) begin
    rst_r <= srst;
  end
  ////////////////////////////////////////////////////////////////
  for (genvar i = 0; i < 4; i++) begin : g_ch
    logic [2:0] s;
    logic [2:0] s_r;
    logic upd;
    logic [9:0] ml;
    logic [9:0] mg;
    logic [9:0] ld;
    assign s = rx_sens_monitor_sel[3*i+:3];
    assign ml = max_loss_tenth_db[10*i+:10];
    assign mg = mon_gain_tenth_db[10*i+:10];
    assign ld = loss_decl_tenth_db[10*i+:10];
    // Decodes register on the same edge as the select; judge them only once it has held a cycle
    assign upd = !rst_r && (s == s_r);
    always_ff @(posedge clk) begin
      s_r <= s;
    end
    chk_mon_mode: assert property (upd |-> monitor_mode_en[i] == (s[2:1] == 2'b10))
      else $error("monitor enable wrong");
    chk_sel_rsvd: assert property (upd |-> sel_reserved[i] == s[1])
      else $error("reserved flag wrong");
    chk_norm_loss: assert property (upd && s[2:1] == 2'b00 |-> mg == 10'd0
      && ml == (s[0] ? MAXLOSS_001 : MAXLOSS_000) && ld == (s[0] ? DECL_001 : DECL_000))
      else $error("normal levels wrong");
    chk_mon_levels: assert property (upd && s[2:1] == 2'b10 |->
      ml == (s[0] ? MAXLOSS_101 : MAXLOSS_100) && mg == (s[0] ? GAIN_MON_20 : GAIN_MON_14)
      && ld == (s[0] ? DECL_101 : DECL_100)) else $error("monitor levels wrong");
    chk_term_ratio: assert property ($stable(rx_ratio_one_to_one[i]) |->
      int_term_allowed[i] == rx_ratio_one_to_one[i]) else $error("termination wrong");
  end
  ////////////////////////////////////////////////////////////////
  chk_wait_pulse: assert property (!waitrequest |=> waitrequest)
    else $error("waitrequest low too long");
  chk_wait_latency: assert property ($rose(read || write) |-> waitrequest ##1 waitrequest ##1 !waitrequest)
    else $error("answer latency wrong");
  chk_wait_cause: assert property ($fell(waitrequest) |-> $past(read || write, 2))
    else $error("answer without request");
  chk_rdata_upper: assert property (!waitrequest |-> readdata[31:8] == 24'h0)
    else $error("upper read lanes set");
endmodule
`default_nettype wire

// ---- tb/rx_sensitivity_level_regs_bench.sv ----
`timescale 1ns/1ps
`default_nettype none
module rx_sensitivity_level_regs_bench
  import rx_sens_pkg::*;
;
  typedef struct packed {logic [7:0] a; logic [7:0] d; logic [7:0] e;} row_s;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic [7:0] address = 8'h00;
  logic read = 1'b0;
  logic write = 1'b0;
  logic [31:0] writedata = 32'h0;
  logic [63:0] meas_level = 64'h0000_F001_0076_5432;
  logic [31:0] readdata;
  logic waitrequest;
  logic [3:0] rat, term, mon, rsv;
  logic [11:0] sel;
  logic [39:0] ml, mg, ld;
  int mismatches = 0;
  int check_count = 0;
  // Level rows write all ones to show the status bytes ignore writes
  row_s rows [8] = '{'{8'h0B, 8'hC1, 8'hC1}, '{8'h2B, 8'h5D, 8'h5D}, '{8'h0C, 8'hFF, 8'h32},
    '{8'h0D, 8'hFF, 8'h54}, '{8'h0E, 8'hFF, 8'h76}, '{8'h2C, 8'hFF, 8'h01},
    '{8'h2D, 8'hFF, 8'h70}, '{8'h0F, 8'hFF, 8'h00}};
  always #12.5 clk = ~clk;
  rx_sensitivity_level_regs dut_u (.clk(clk), .srst(srst), .address(address), .read(read),
    .write(write), .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest),
    .meas_level(meas_level), .rx_ratio_one_to_one(rat), .rx_sens_monitor_sel(sel),
    .int_term_allowed(term), .monitor_mode_en(mon), .sel_reserved(rsv),
    .max_loss_tenth_db(ml), .mon_gain_tenth_db(mg), .loss_decl_tenth_db(ld));
  ////////////////////////////////////////////////////////////////
  task automatic check(input logic [39:0] got, input logic [39:0] exp, input string msg);
    check_count++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH t=%0t %s got %0h", $time, msg, got);
    end
  endtask
  task automatic bus(input logic [7:0] a, input logic wr, input logic [7:0] d,
      output logic [7:0] q);
    address <= a;
    writedata <= {24'h0, d};
    write <= wr;
    read <= !wr;
    // No cycle count assumed here; only the watchdog ends a hung access
    do begin
      @(posedge clk);
    end while (waitrequest !== 1'b0);
    q = readdata[7:0];
    check(readdata[31:8], 24'h00_0000, "upper lanes");
    read <= 1'b0;
    write <= 1'b0;
    @(posedge clk);
  endtask
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////
  initial begin
    logic [7:0] q;
    repeat (6) @(posedge clk);
    srst <= 1'b0;
    @(posedge clk);
    foreach (rows[k]) begin
      bus(rows[k].a, 1'b1, rows[k].d, q);
      bus(rows[k].a, 1'b0, 8'h00, q);
      check(q, rows[k].e, "readback");
    end
    check(rat, 4'b0110, "ratio");
    check(term, 4'b0110, "termination");
    check(sel, 12'hB61, "select");
    check(mon, 4'b1110, "monitor");
    check(ml, {MAXLOSS_101, MAXLOSS_101, MAXLOSS_100, MAXLOSS_001}, "loss");
    check(mg, {GAIN_MON_20, GAIN_MON_20, GAIN_MON_14, 10'd0}, "gain");
    check(ld, {DECL_101, DECL_101, DECL_100, DECL_001}, "decl");
    $display("table test done");
    bus(8'h0B, 1'b1, 8'h32, q);
    repeat (2) @(posedge clk);
    check(rsv, 4'b0011, "reserved");
    meas_level[3:0] <= 4'h5;
    bus(8'h0C, 1'b0, 8'h00, q);
    check(q, 8'h35, "level follow");
    $display("reserved and level test done");
    srst <= 1'b1;
    repeat (2) @(posedge clk);
    srst <= 1'b0;
    @(posedge clk);
    bus(8'h2B, 1'b0, 8'h00, q);
    check(q, 8'h00, "reset value");
    check(ml, {4{MAXLOSS_000}}, "reset loss");
    check(ld, {4{DECL_000}}, "reset decl");
    $display("reset test done");
    print_verdict();
  end
  initial begin
    #50000;
    mismatches++;
    $display("MISMATCH t=%0t timeout", $time);
    print_verdict();
  end
endmodule
bind rx_sensitivity_level_regs rx_sens_monitor chk_u (.clk(clk), .srst(srst), .read(read),
  .write(write), .readdata(readdata), .waitrequest(waitrequest),
  .rx_ratio_one_to_one(rx_ratio_one_to_one), .rx_sens_monitor_sel(rx_sens_monitor_sel),
  .int_term_allowed(int_term_allowed), .monitor_mode_en(monitor_mode_en),
  .sel_reserved(sel_reserved), .max_loss_tenth_db(max_loss_tenth_db),
  .mon_gain_tenth_db(mon_gain_tenth_db), .loss_decl_tenth_db(loss_decl_tenth_db));
`default_nettype wire
